// file: mfl_cfg.svh
// Constants of the mass flow register bank and limit checker
// Contract
// - 32-bit items sit in even-addressed register pairs, accessed as one pair.
// - Holding registers decode in 0x6000 to 0x6FFE.
// - Input registers decode in 0x4000 to 0x4FFE.
// - Fast-access input register sets decode in 0x5000 to 0x5FFE.
// - Holding registers also answer 0x6000 lower, in 0x0000 to 0x0FFE.
// - Input registers also answer in 0x1000 to 0x1FFE with identical values.
// - Fast span 0x5000 to 0x5300 also answers at 0x2000 to 0x2300.
// - Flow below the cut-off in one sample is reported as zero.
// - Flow below the cut-off is never passed to the totalizers.
// - Cut-off defaults to 0.01 kg/min.
// - Flow above the upper warning limit sets warnings bit 1 at 0x401E.
// - Flow below the lower warning limit also sets warnings bit 1.
// - Warning limits span -35000 to +35000 kg/min; defaults are the extremes.
// - Warning sets after a programmable count of consecutive 10 ms violations, default 3.
// - Cut-off and warning limits use the unit chosen at 0x6106.
// - Density reference 0 to 12000 kg/m3, default 998, converted per unit at 0x6108.
`ifndef MFL_CFG_SVH
`define MFL_CFG_SVH

// ----------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------
`define MFL_HOLD_LO 16'h6000
`define MFL_HOLD_HI 16'h6ffe
`define MFL_INPUT_LO 16'h4000
`define MFL_INPUT_HI 16'h4ffe
`define MFL_FAST_LO 16'h5000
`define MFL_FAST_HI 16'h5ffe
`define MFL_MIR_HOLD_HI 16'h0ffe
`define MFL_MIR_INPUT_HI 16'h1ffe
`define MFL_MIR_FAST_LO 16'h2000
`define MFL_MIR_FAST_HI 16'h2300
`define MFL_MIR_HOLD_OFS 16'h6000
`define MFL_MIR_HIGH_OFS 16'h3000

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MFL_REG_CUTOFF 16'h6924
`define MFL_REG_UPPER 16'h6926
`define MFL_REG_LOWER 16'h6928
`define MFL_REG_THRESH 16'h692a
`define MFL_REG_DENS 16'h693e
`define MFL_REG_FLOW_UNIT 16'h6106
`define MFL_REG_DENS_UNIT 16'h6108
`define MFL_REG_FLOW 16'h4000
`define MFL_REG_WARN 16'h401e
`define MFL_REG_FAST_FLOW 16'h5000
`define MFL_REG_FAST_WARN 16'h5002

// ----------------------------------------------------------------
// Fields and reset values (flow LSB is 0.01 in the selected unit)
// ----------------------------------------------------------------
`define MFL_WARN_RANGE_BIT 1
`define MFL_RST_CUTOFF 32'h0000_0001
`define MFL_RST_UPPER 32'h0035_67e0
`define MFL_RST_LOWER 32'hffca_9820
`define MFL_LIMIT_MAX 32'h0035_67e0
`define MFL_LIMIT_MIN 32'hffca_9820
`define MFL_RST_THRESH 32'h0000_0003
`define MFL_RST_DENS 32'h0000_03e6
`define MFL_DENS_MAX 32'h0000_2ee0
`define MFL_RST_UNIT 32'h0000_0000

// ----------------------------------------------------------------
// Timing and density scaling (lb/ft3 in units of 0.001)
// ----------------------------------------------------------------
`define MFL_TICK_MS 10
`define MFL_CLK_KHZ 25000
`define MFL_LBFT3_TO_KGM3 32'h0000_041a
`define MFL_LBFT3_TO_KGM3_SH 16
`define MFL_KGM3_TO_LBFT3 32'h0000_f9b6
`define MFL_KGM3_TO_LBFT3_SH 10

`endif

// file: mfl_pkg.sv
// Types shared by the mass flow register bank
package mfl_pkg;

  // Register space an access falls in after mirror folding
  typedef enum logic [1:0]
  {
    SPACE_HOLD = 2'b00,
    SPACE_INPUT = 2'b01,
    SPACE_FAST = 2'b10,
    SPACE_NONE = 2'b11
  } space_t;

  // Density units that the conversion path knows
  typedef enum logic [1:0]
  {
    DENS_KG_M3 = 2'b00,
    DENS_G_L = 2'b01,
    DENS_LB_FT3 = 2'b10,
    DENS_RSVD = 2'b11
  } dens_unit_t;

endpackage

// file: mfl_warn_integrator.sv
// Consecutive-violation fault integrator for the flow warning bit
module mfl_warn_integrator
#(
  parameter int CNT_W = 32
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Evaluation strobe and operands
  input wire logic i_tick,
  input wire logic signed [31:0] i_flow,
  input wire logic signed [31:0] i_upper,
  input wire logic signed [31:0] i_lower,
  input wire logic [CNT_W-1:0] i_thresh,
  // Result
  output logic o_warn,
  output logic [CNT_W-1:0] o_count
);

  logic viol;
  logic [CNT_W-1:0] count_d;

  assign viol = (i_flow > i_upper) || (i_flow < i_lower);
  // Saturate so a long excursion never wraps back to an in-range count
  assign count_d = (o_count == {CNT_W{1'b1}}) ? o_count : o_count + 1'b1;

  // ----------------------------------------------------------------
  // Counter and warning
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_count <= '0;
      o_warn <= 1'b0;
    end
    else if (i_tick)
    begin
      if (viol)
      begin
        o_count <= count_d;
        o_warn <= o_warn || (count_d >= i_thresh);
      end
      else
      begin
        o_count <= '0;
        o_warn <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_warn_after_count;
    @(posedge i_clk) disable iff (!i_nrst)
      i_tick && viol && (count_d >= i_thresh) |=> o_warn;
  endproperty
  a_warn_after_count: assert property (p_warn_after_count) else $error("warning late");

  property p_no_early_warn;
    @(posedge i_clk) disable iff (!i_nrst)
      i_tick && !o_warn && (count_d < i_thresh) |=> !o_warn;
  endproperty
  a_no_early_warn: assert property (p_no_early_warn) else $error("warning early");

  property p_in_range_clears;
    @(posedge i_clk) disable iff (!i_nrst)
      i_tick && !viol |=> !o_warn && (o_count == '0);
  endproperty
  a_in_range_clears: assert property (p_in_range_clears) else $error("no clear in range");

  c_warn_rise: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_warn));

endmodule // mfl_warn_integrator

// file: mfl_register_bank.sv
// Mass flow register bank with cut-off and warning limit checking
`include "mfl_cfg.svh"

module mfl_register_bank
#(
  parameter int TICK_CYCLES = `MFL_TICK_MS * `MFL_CLK_KHZ
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register access: one request carries a full 32-bit pair
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic o_err,
  output logic [31:0] o_rdata,
  // Measurement cycle
  input wire logic i_sample,
  input wire logic signed [31:0] i_flow,
  output logic signed [31:0] o_flow,
  output logic o_total_en,
  output logic signed [31:0] o_total_flow,
  // Status and unit for the measurement path
  output logic o_warn,
  output logic [31:0] o_flow_unit
);

  logic signed [31:0] cutoff_q;
  logic signed [31:0] upper_q;
  logic signed [31:0] lower_q;
  logic [31:0] thresh_q;
  logic [31:0] dens_q;
  logic [31:0] dens_unit_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic signed [31:0] flow_mag;
  logic below_cut;
  logic [15:0] addr_n;
  mfl_pkg::space_t space;
  logic [31:0] rdata_d;
  logic hit_d;
  logic warn_int;
  logic [31:0] warn_cnt;
  logic wr_ok;

  // ----------------------------------------------------------------
  // Address folding and window decode
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_n = i_addr;
    space = mfl_pkg::SPACE_NONE;
    if (i_addr <= `MFL_MIR_HOLD_HI)
    begin
      addr_n = i_addr + `MFL_MIR_HOLD_OFS;
      space = mfl_pkg::SPACE_HOLD;
    end
    else if (i_addr <= `MFL_MIR_INPUT_HI)
    begin
      addr_n = i_addr + `MFL_MIR_HIGH_OFS;
      space = mfl_pkg::SPACE_INPUT;
    end
    else if (i_addr >= `MFL_MIR_FAST_LO && i_addr <= `MFL_MIR_FAST_HI)
    begin
      addr_n = i_addr + `MFL_MIR_HIGH_OFS;
      space = mfl_pkg::SPACE_FAST;
    end
    else if (i_addr >= `MFL_HOLD_LO && i_addr <= `MFL_HOLD_HI)
      space = mfl_pkg::SPACE_HOLD;
    else if (i_addr >= `MFL_INPUT_LO && i_addr <= `MFL_INPUT_HI)
      space = mfl_pkg::SPACE_INPUT;
    else if (i_addr >= `MFL_FAST_LO && i_addr <= `MFL_FAST_HI)
      space = mfl_pkg::SPACE_FAST;
    // Odd addresses would split a pair, so they hit nothing
    if (i_addr[0])
      space = mfl_pkg::SPACE_NONE;
  end

  // ----------------------------------------------------------------
  // Read data; unimplemented words in a window read as zero
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    hit_d = (space != mfl_pkg::SPACE_NONE);
    if (space == mfl_pkg::SPACE_HOLD)
    begin
      if (addr_n == `MFL_REG_CUTOFF)
        rdata_d = cutoff_q;
      else if (addr_n == `MFL_REG_UPPER)
        rdata_d = upper_q;
      else if (addr_n == `MFL_REG_LOWER)
        rdata_d = lower_q;
      else if (addr_n == `MFL_REG_THRESH)
        rdata_d = thresh_q;
      else if (addr_n == `MFL_REG_DENS)
        rdata_d = dens_to_unit(dens_q, dens_unit_q);
      else if (addr_n == `MFL_REG_FLOW_UNIT)
        rdata_d = o_flow_unit;
      else if (addr_n == `MFL_REG_DENS_UNIT)
        rdata_d = dens_unit_q;
    end
    else if (space == mfl_pkg::SPACE_INPUT)
    begin
      if (addr_n == `MFL_REG_FLOW)
        rdata_d = o_flow;
      else if (addr_n == `MFL_REG_WARN)
        rdata_d = {30'h0, o_warn, 1'b0};
    end
    else if (space == mfl_pkg::SPACE_FAST)
    begin
      if (addr_n == `MFL_REG_FAST_FLOW)
        rdata_d = o_flow;
      else if (addr_n == `MFL_REG_FAST_WARN)
        rdata_d = {30'h0, o_warn, 1'b0};
    end
  end

  // Density conversion between the stored kg/m3 and the selected unit
  function automatic logic [31:0] dens_to_unit(input logic [31:0] v, input logic [31:0] u);
    logic [63:0] p;
    p = 64'(v) * 64'(`MFL_KGM3_TO_LBFT3);
    if (u[1:0] == mfl_pkg::DENS_LB_FT3)
      return p[`MFL_KGM3_TO_LBFT3_SH +: 32];
    return v;
  endfunction

  function automatic logic [31:0] dens_from_unit(input logic [31:0] v, input logic [31:0] u);
    logic [63:0] p;
    logic [31:0] k;
    p = 64'(v) * 64'(`MFL_LBFT3_TO_KGM3);
    k = v;
    if (u[1:0] == mfl_pkg::DENS_LB_FT3)
      k = p[`MFL_LBFT3_TO_KGM3_SH +: 32];
    if (k > `MFL_DENS_MAX)
      k = `MFL_DENS_MAX;
    return k;
  endfunction

  function automatic logic signed [31:0] clamp_limit(input logic signed [31:0] v);
    if (v > $signed(`MFL_LIMIT_MAX))
      return $signed(`MFL_LIMIT_MAX);
    if (v < $signed(`MFL_LIMIT_MIN))
      return $signed(`MFL_LIMIT_MIN);
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Access answer
  // ----------------------------------------------------------------
  assign wr_ok = i_req && i_wr && (space == mfl_pkg::SPACE_HOLD);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= '0;
    end
    else
    begin
      o_ack <= i_req;
      // Input registers are read only; writing them is an exception
      o_err <= i_req && (!hit_d || (i_wr && space != mfl_pkg::SPACE_HOLD));
      o_rdata <= (i_req && !i_wr) ? rdata_d : '0;
    end
  end

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cutoff_q <= `MFL_RST_CUTOFF;
      upper_q <= `MFL_RST_UPPER;
      lower_q <= `MFL_RST_LOWER;
      thresh_q <= `MFL_RST_THRESH;
      dens_q <= `MFL_RST_DENS;
      o_flow_unit <= `MFL_RST_UNIT;
      dens_unit_q <= `MFL_RST_UNIT;
    end
    else if (wr_ok)
    begin
      if (addr_n == `MFL_REG_CUTOFF)
        cutoff_q <= i_wdata;
      else if (addr_n == `MFL_REG_UPPER)
        upper_q <= clamp_limit(i_wdata);
      else if (addr_n == `MFL_REG_LOWER)
        lower_q <= clamp_limit(i_wdata);
      else if (addr_n == `MFL_REG_THRESH)
        thresh_q <= i_wdata;
      else if (addr_n == `MFL_REG_DENS)
        dens_q <= dens_from_unit(i_wdata, dens_unit_q);
      else if (addr_n == `MFL_REG_FLOW_UNIT)
        o_flow_unit <= i_wdata;
      else if (addr_n == `MFL_REG_DENS_UNIT)
        dens_unit_q <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Cut-off and totalizer feed; limits share the flow input's unit
  // ----------------------------------------------------------------
  assign flow_mag = (i_flow < 0) ? -i_flow : i_flow;
  assign below_cut = flow_mag < cutoff_q;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_flow <= '0;
      o_total_en <= 1'b0;
      o_total_flow <= '0;
    end
    else
    begin
      o_total_en <= i_sample && !below_cut;
      if (i_sample)
      begin
        o_flow <= below_cut ? '0 : i_flow;
        o_total_flow <= below_cut ? '0 : i_flow;
      end
    end
  end

  // ----------------------------------------------------------------
  // 10 ms evaluation tick and fault integrator
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      tick_cnt_q <= '0;
    else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  mfl_warn_integrator #(
    .CNT_W(32)
  ) u_warn (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick),
    .i_flow(o_flow),
    .i_upper(upper_q),
    .i_lower(lower_q),
    .i_thresh(thresh_q),
    .o_warn(warn_int),
    .o_count(warn_cnt)
  );

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_warn <= 1'b0;
    else
      o_warn <= warn_int;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_odd_refused;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && i_addr[0] |=> o_ack && o_err;
  endproperty
  a_odd_refused: assert property (p_odd_refused) else $error("odd address accepted");

  property p_hold_window;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && !i_addr[0] && i_addr >= 16'h6000 && i_addr <= 16'h6ffe |=> !o_err;
  endproperty
  a_hold_window: assert property (p_hold_window) else $error("holding refused");

  property p_input_window;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && !i_wr && !i_addr[0] && i_addr >= 16'h4000 && i_addr <= 16'h4ffe |=> !o_err;
  endproperty
  a_input_window: assert property (p_input_window) else $error("input refused");

  property p_fast_window;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && !i_wr && !i_addr[0] && i_addr >= 16'h5000 && i_addr <= 16'h5ffe |=> !o_err;
  endproperty
  a_fast_window: assert property (p_fast_window) else $error("fast refused");

  property p_hold_mirror;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && !i_wr && i_addr == 16'h0924 |=> o_rdata == $past(cutoff_q) && !o_err;
  endproperty
  a_hold_mirror: assert property (p_hold_mirror) else $error("holding mirror wrong");

  property p_input_mirror;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && !i_wr && i_addr == 16'h101e |=> o_rdata[1] == $past(o_warn) && !o_err;
  endproperty
  a_input_mirror: assert property (p_input_mirror) else $error("input mirror wrong");

  property p_fast_mirror;
    @(posedge i_clk) disable iff (!i_nrst)
      i_req && !i_wr && i_addr == 16'h2000 |=> o_rdata == $past(o_flow) && !o_err;
  endproperty
  a_fast_mirror: assert property (p_fast_mirror) else $error("fast mirror wrong");

  property p_cut_zero;
    @(posedge i_clk) disable iff (!i_nrst)
      i_sample && below_cut |=> o_flow == 0 && !o_total_en;
  endproperty
  a_cut_zero: assert property (p_cut_zero) else $error("cut flow leaked");

  property p_total_pass;
    @(posedge i_clk) disable iff (!i_nrst)
      i_sample && !below_cut |=> o_total_en && o_total_flow == $past(i_flow);
  endproperty
  a_total_pass: assert property (p_total_pass) else $error("flow not totalized");

  property p_limit_clamp;
    @(posedge i_clk) disable iff (!i_nrst)
      wr_ok && addr_n == 16'h6926 && $signed(i_wdata) > 32'sd3500000
      |=> upper_q == 32'sd3500000;
  endproperty
  a_limit_clamp: assert property (p_limit_clamp) else $error("limit not clamped");

  property p_dens_clamp;
    @(posedge i_clk) disable iff (!i_nrst)
      wr_ok && addr_n == 16'h693e && dens_unit_q == 0 && i_wdata > 32'd12000
      |=> dens_q == 32'd12000;
  endproperty
  a_dens_clamp: assert property (p_dens_clamp) else $error("density not clamped");

  // The warning can only stand on a non-zero violation count
  property p_warn_count;
    @(posedge i_clk) disable iff (!i_nrst)
      warn_int |-> warn_cnt != '0;
  endproperty
  a_warn_count: assert property (p_warn_count) else $error("warning without count");

  c_cut: cover property (@(posedge i_clk) disable iff (!i_nrst) i_sample && below_cut);
  c_mirror_write: cover property (@(posedge i_clk) disable iff (!i_nrst) wr_ok && i_addr < 16'h1000);
  c_warn: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_warn));

endmodule // mfl_register_bank

// file: mfl_host_model.sv
// Behavioural register host that issues whole-pair accesses to the bank
module mfl_host_model
(
  // Clock
  input wire logic i_clk,
  // Answer from the bank
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [31:0] i_rdata,
  // Request to the bank
  output logic o_req,
  output logic o_wr,
  output logic [15:0] o_addr,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h0000_0000;
  end

  // Caller stands just past an edge; rel=0 leaves the lines up for a back-to-back access
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        input bit rel, output logic [31:0] rd, output logic ack,
                        output logic err);
    o_req = 1'b1;
    o_wr = wr;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    rd = i_rdata;
    ack = i_ack;
    err = i_err;
    if (rel)
    begin
      // Released lines show the inverse so a stale value cannot pass for a fresh one
      o_req = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      // One idle edge keeps the next call from re-raising the request in this time step
      @(posedge i_clk);
      #1;
    end
  endtask
endmodule // mfl_host_model

// file: tb.sv
// Self-checking bench for the mass flow register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Short measurement tick keeps warning runs brief
  localparam int TICKS = 8;

  typedef struct {
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic err;
    logic [31:0] rdata;
  } reg_row_t;

  typedef struct {
    logic [31:0] flow;
    logic [31:0] exp;
    logic en;
  } meas_row_t;

  logic i_clk, i_nrst, i_sample;
  logic signed [31:0] i_flow;
  logic req, wr, o_ack, o_err, o_total_en, o_warn, ack, err;
  logic [15:0] addr;
  logic [31:0] wdata, o_rdata, o_flow_unit, rd;
  logic signed [31:0] o_flow, o_total_flow;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  reg_row_t regs[] = '{
    '{1'b0, 16'h6924, 32'h0, 1'b0, 32'h1},
    '{1'b0, 16'h6926, 32'h0, 1'b0, 32'h0035_67e0},
    '{1'b0, 16'h6928, 32'h0, 1'b0, 32'hffca_9820},
    '{1'b0, 16'h692a, 32'h0, 1'b0, 32'h3},
    '{1'b0, 16'h693e, 32'h0, 1'b0, 32'h3e6},
    '{1'b0, 16'h6106, 32'h0, 1'b0, 32'h0},
    '{1'b0, 16'h6925, 32'h0, 1'b1, 32'h0},
    '{1'b0, 16'h7000, 32'h0, 1'b1, 32'h0},
    '{1'b0, 16'h3ffe, 32'h0, 1'b1, 32'h0},
    '{1'b0, 16'h2302, 32'h0, 1'b1, 32'h0},
    '{1'b1, 16'h4000, 32'h5, 1'b1, 32'h0},
    '{1'b1, 16'h2000, 32'h5, 1'b1, 32'h0},
    '{1'b0, 16'h6ffe, 32'h0, 1'b0, 32'h0},
    '{1'b0, 16'h0ffe, 32'h0, 1'b0, 32'h0},
    '{1'b0, 16'h4ffe, 32'h0, 1'b0, 32'h0},
    '{1'b0, 16'h1ffe, 32'h0, 1'b0, 32'h0},
    '{1'b0, 16'h5ffe, 32'h0, 1'b0, 32'h0},
    '{1'b1, 16'h6926, 32'h8000_0000, 1'b0, 32'h0},
    '{1'b0, 16'h0926, 32'h0, 1'b0, 32'hffca_9820},
    '{1'b1, 16'h0926, 32'h3e8, 1'b0, 32'h0},
    '{1'b0, 16'h6926, 32'h0, 1'b0, 32'h3e8},
    '{1'b1, 16'h693e, 32'h4e20, 1'b0, 32'h0},
    '{1'b0, 16'h093e, 32'h0, 1'b0, 32'h2ee0},
    '{1'b1, 16'h6108, 32'h2, 1'b0, 32'h0},
    '{1'b0, 16'h693e, 32'h0, 1'b0, 32'h000b_6e4c},
    '{1'b1, 16'h693e, 32'h0000_f3dc, 1'b0, 32'h0},
    '{1'b1, 16'h6108, 32'h0, 1'b0, 32'h0},
    '{1'b0, 16'h693e, 32'h0, 1'b0, 32'h3e8},
    '{1'b1, 16'h6924, 32'h1f4, 1'b0, 32'h0},
    '{1'b1, 16'h6925, 32'hffff_ffff, 1'b1, 32'h0},
    '{1'b0, 16'h6924, 32'h0, 1'b0, 32'h1f4}
  };

  meas_row_t meas[] = '{
    '{32'h0, 32'h0, 1'b0},
    '{32'h1f3, 32'h0, 1'b0},
    '{32'hffff_fe0d, 32'h0, 1'b0},
    '{32'h1f4, 32'h1f4, 1'b1},
    '{32'hffff_fda8, 32'hffff_fda8, 1'b1},
    '{32'h1f3, 32'h0, 1'b0}
  };

  mfl_register_bank #(.TICK_CYCLES(TICKS)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req),
    .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_ack(o_ack), .o_err(o_err),
    .o_rdata(o_rdata), .i_sample(i_sample), .i_flow(i_flow), .o_flow(o_flow),
    .o_total_en(o_total_en), .o_total_flow(o_total_flow), .o_warn(o_warn),
    .o_flow_unit(o_flow_unit));

  mfl_host_model host (.i_clk(i_clk), .i_ack(o_ack), .i_err(o_err), .i_rdata(o_rdata),
    .o_req(req), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rw(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic e, input logic [31:0] x);
    host.access(w, a, d, 1'b1, rd, ack, err);
    chk({31'h0, ack}, 32'h1);
    chk({31'h0, err}, {31'h0, e});
    chk(rd, x);
  endtask

  task automatic samp(input logic [31:0] f, input logic [31:0] x, input logic en);
    i_sample = 1'b1;
    i_flow = f;
    @(posedge i_clk);
    #1;
    i_sample = 1'b0;
    i_flow = ~f;
    chk(o_flow, x);
    chk({31'h0, o_total_en}, {31'h0, en});
    chk(o_total_flow, en ? x : 32'h0);
    // Idle edge: the strobe is not re-raised in this time step, and the pulse must end
    @(posedge i_clk);
    #1;
    chk({31'h0, o_total_en}, 32'h0);
    chk(o_flow, x);
  endtask

  // Edges after the sample's idle edge until the warning reaches lvl must fall in [lo, hi]
  task automatic warn_lat(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (o_warn !== lvl && n < 40)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    i_nrst = 1'b0;
    i_sample = 1'b0;
    i_flow = 32'h0;
    repeat (10) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    foreach (regs[k]) rw(regs[k].wr, regs[k].addr, regs[k].wdata, regs[k].err, regs[k].rdata);
    foreach (meas[k]) samp(meas[k].flow, meas[k].exp, meas[k].en);
    // Upper limit 1000 with the default three-tick integrator
    samp(32'h3e9, 32'h3e9, 1'b1);
    warn_lat(1'b1, 17, 24);
    rw(1'b0, 16'h4000, 32'h0, 1'b0, 32'h3e9);
    rw(1'b0, 16'h1000, 32'h0, 1'b0, 32'h3e9);
    rw(1'b0, 16'h5000, 32'h0, 1'b0, 32'h3e9);
    rw(1'b0, 16'h2000, 32'h0, 1'b0, 32'h3e9);
    rw(1'b0, 16'h401e, 32'h0, 1'b0, 32'h2);
    rw(1'b0, 16'h101e, 32'h0, 1'b0, 32'h2);
    rw(1'b0, 16'h5002, 32'h0, 1'b0, 32'h2);
    rw(1'b0, 16'h2002, 32'h0, 1'b0, 32'h2);
    samp(32'h3e8, 32'h3e8, 1'b1);
    warn_lat(1'b0, 1, 8);
    rw(1'b1, 16'h6106, 32'h2, 1'b0, 32'h0);
    chk(o_flow_unit, 32'h2);
    // Back-to-back: the read issued in the ack cycle sees the new count
    host.access(1'b1, 16'h692a, 32'h1, 1'b0, rd, ack, err);
    chk({31'h0, ack}, 32'h1);
    rw(1'b0, 16'h692a, 32'h0, 1'b0, 32'h1);
    rw(1'b1, 16'h0928, 32'hffff_ff9c, 1'b0, 32'h0);
    samp(32'hffff_fda8, 32'hffff_fda8, 1'b1);
    warn_lat(1'b1, 1, 8);
    // Reset in mid-run with the warning raised
    i_nrst = 1'b0;
    #1;
    chk({31'h0, o_warn}, 32'h0);
    chk(o_flow, 32'h0);
    chk(o_total_flow, 32'h0);
    chk(o_flow_unit, 32'h0);
    repeat (2) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    rw(1'b0, 16'h6928, 32'h0, 1'b0, 32'hffca_9820);
    rw(1'b0, 16'h6924, 32'h0, 1'b0, 32'h1);
    rw(1'b0, 16'h692a, 32'h0, 1'b0, 32'h3);
    rw(1'b0, 16'h6926, 32'h0, 1'b0, 32'h0035_67e0);
    rw(1'b0, 16'h693e, 32'h0, 1'b0, 32'h3e6);
    rw(1'b0, 16'h6106, 32'h0, 1'b0, 32'h0);
    conclude();
  end
endmodule // tb
